/* hw/ccpw_pkg.sv */
// ccpw_pkg: constants and carrier types of the single-output pwm block.
// assumes a 32-bit apb slave, byte addresses, one register per aligned word.
package ccpw_pkg;
   localparam int ADDR_W = 8;
   localparam int NUM_UNITS = 2;
   // register byte offsets
   localparam logic [7:0] OFF_PT_COUNT = 8'h00;
   localparam logic [7:0] OFF_PT_PERIOD = 8'h04;
   localparam logic [7:0] OFF_PT_CONTROL = 8'h08;
   localparam logic [7:0] OFF_AT_COUNT = 8'h0c;
   localparam logic [7:0] OFF_AT_PERIOD = 8'h10;
   localparam logic [7:0] OFF_AT_CONTROL = 8'h14;
   localparam logic [7:0] OFF_U4_DUTY_LOW = 8'h18;
   localparam logic [7:0] OFF_U4_DUTY_HIGH = 8'h1c;
   localparam logic [7:0] OFF_U5_DUTY_LOW = 8'h20;
   localparam logic [7:0] OFF_U5_DUTY_HIGH = 8'h24;
   localparam logic [7:0] OFF_U4_CONTROL = 8'h28;
   localparam logic [7:0] OFF_U5_CONTROL = 8'h2c;
   localparam logic [7:0] OFF_OPEN_DRAIN = 8'h30;
   localparam logic [7:0] OFF_PIN_DIR = 8'h34;
   localparam logic [7:0] OFF_TIMER_SEL = 8'h38;
   localparam logic [7:0] OFF_STATUS = 8'h3c;
   // field positions
   localparam int OD_U4_BIT = 3;
   localparam int OD_U5_BIT = 4;
   localparam int ST_POST_LSB = 0;
   localparam int ST_PIN_LSB = 2;
   // values after reset
   localparam logic [7:0] RST_PERIOD = 8'hff;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [1:0] RST_PIN_DIR = 2'h3;
   // timer sub-counter terminal counts: 4 oscillator cycles times prescale
   localparam logic [5:0] SUB_LIMIT_1 = 6'h03;
   localparam logic [5:0] SUB_LIMIT_4 = 6'h0f;
   localparam logic [5:0] SUB_LIMIT_16 = 6'h3f;
   // mode select upper bits that pick pwm
   localparam logic [1:0] MODE_PWM_HI = 2'h3;

   typedef enum logic [1:0] {CCPW_PRE_1 = 2'h0, CCPW_PRE_4 = 2'h1, CCPW_PRE_16A = 2'h2,
                             CCPW_PRE_16B = 2'h3} ccpw_pre_t;
   typedef struct packed {
      logic [3:0] postscale;
      logic run;
      ccpw_pre_t prescale;
   } ccpw_tctl_t;
   typedef struct packed {
      logic [1:0] duty_low_bits;
      logic [3:0] mode;
   } ccpw_uctl_t;
   // timer state seen by a pwm unit
   typedef struct packed {
      logic [7:0] count;
      logic [1:0] phase;
      logic rollover;
   } ccpw_tbase_t;
endpackage : ccpw_pkg

/* hw/ccpw_timer.sv */
// ccpw_timer: 8-bit period timer with 1/4/16 prescale and a postscaler.
// assumes pclk is the oscillator clock; one timer tick is four pclk times prescale.
`timescale 1ns/100ps
module ccpw_timer (
   input wire logic pclk,
   input wire logic presetn,
   input wire ccpw_pkg::ccpw_tctl_t ctl,
   input wire logic [7:0] period,
   input wire logic load,
   input wire logic [7:0] load_val,
   output ccpw_pkg::ccpw_tbase_t tbase,
   output logic post_evt
);
   logic [5:0] sub_r;
   logic [7:0] count_r;
   logic [3:0] post_r;
   logic [5:0] limit;
   logic tick;
   logic roll;

   // prescale picks how many oscillator cycles make one timer increment
   always_comb begin
      unique case (ctl.prescale)
         ccpw_pkg::CCPW_PRE_1: limit = ccpw_pkg::SUB_LIMIT_1;
         ccpw_pkg::CCPW_PRE_4: limit = ccpw_pkg::SUB_LIMIT_4;
         default: limit = ccpw_pkg::SUB_LIMIT_16;
      endcase
   end
   assign tick = ctl.run && (sub_r == limit);
   assign roll = tick && (count_r == period);

   // sub-counter: quarter-cycle phase plus prescaler, restarted by a count write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sub_r <= 6'h00;
      end else if (load || tick) begin
         sub_r <= 6'h00;
      end else if (ctl.run) begin
         sub_r <= sub_r + 6'h01;
      end
   end

   // timer count clears on the increment after it equals the period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= ccpw_pkg::RST_COUNT;
      end else if (load) begin
         count_r <= load_val;
      end else if (roll) begin
         count_r <= 8'h00;
      end else if (tick) begin
         count_r <= count_r + 8'h01;
      end
   end

   // postscaler only makes a slower event; it never touches the period
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_r <= 4'h0;
         post_evt <= 1'b0;
      end else begin
         post_evt <= roll && (post_r == ctl.postscale);
         if (roll) begin
            post_r <= (post_r == ctl.postscale) ? 4'h0 : post_r + 4'h1;
         end
      end
   end

   // the two extra compare bits step once per prescale oscillator cycles
   always_comb begin
      tbase.count = count_r;
      tbase.rollover = roll;
      unique case (ctl.prescale)
         ccpw_pkg::CCPW_PRE_1: tbase.phase = sub_r[1:0];
         ccpw_pkg::CCPW_PRE_4: tbase.phase = sub_r[3:2];
         default: tbase.phase = sub_r[5:4];
      endcase
   end
endmodule : ccpw_timer

/* hw/ccpw_unit.sv */
// ccpw_unit: one pwm channel with a double-buffered 10-bit duty value.
// assumes the time base comes from a ccpw_timer on the same clock.
`timescale 1ns/100ps
module ccpw_unit (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pwm_en,
   input wire logic [7:0] duty_byte,
   input wire logic [1:0] duty_bits,
   input wire logic buf_load,
   input wire logic [7:0] buf_val,
   input wire ccpw_pkg::ccpw_tbase_t tbase,
   output logic [7:0] buf_byte,
   output logic level
);
   logic [1:0] lat2_r; // hidden from software on purpose
   logic [9:0] duty_next;
   logic start_r;

   assign duty_next = {duty_byte, duty_bits};

   // active duty copy: in pwm mode loaded only at rollover so the edge never glitches
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_byte <= 8'h00;
         lat2_r <= 2'h0;
      end else if (pwm_en && tbase.rollover) begin
         {buf_byte, lat2_r} <= duty_next;
      end else if (!pwm_en && buf_load) begin
         buf_byte <= buf_val; // only writable outside pwm mode
      end
   end

   // the match clear lands one edge after the compare, so the set is delayed alike;
   // otherwise every high time would be one oscillator cycle too long
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_r <= 1'b0;
      end else begin
         start_r <= pwm_en && tbase.rollover;
      end
   end

   // output latch: set at period start, cleared on duty match, low when off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level <= 1'b0;
      end else if (!pwm_en) begin
         level <= 1'b0;
      end else if (start_r) begin
         level <= ({buf_byte, lat2_r} != 10'h000);
      end else if ({buf_byte, lat2_r} == {tbase.count, tbase.phase}) begin
         level <= 1'b0; // a duty past the period never matches
      end
   end
endmodule : ccpw_unit

/* hw/ccpw_top.sv */
// ccpw_top: apb register file, two timers and two single-output pwm units.
// assumes an apb master on pclk; pins are driven through out/oe pairs.
`timescale 1ns/100ps
module ccpw_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ccpw_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [1:0] pwm_pin_out,
   output logic [1:0] pwm_pin_oe
);
   // timer configuration and period, index 0 primary, 1 alternate
   ccpw_pkg::ccpw_tctl_t tctl_r [2];
   logic [7:0] period_r [2];
   logic [1:0] count_load;
   ccpw_pkg::ccpw_tbase_t tbase [2];
   logic [1:0] post_evt;

   // unit registers, index 0 unit4, 1 unit5
   ccpw_pkg::ccpw_uctl_t uctl_r [2];
   logic [7:0] duty_low_r [2];
   logic [1:0] buf_load;
   logic [7:0] buf_byte [2];
   logic [1:0] level;
   logic [1:0] pwm_en;

   // pin and shared configuration
   logic [4:0] open_drain_r;
   logic [1:0] pin_dir_r; // 1 = input, like a direction latch
   logic [1:0] timer_sel_r; // per unit: 0 primary timer, 1 alternate
   logic [1:0] post_flag_r;

   // apb decode
   logic wr_acc;
   logic rd_setup;
   logic mapped;
   logic [31:0] rd_val;
   logic [7:0] wbyte;

   assign wr_acc = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign wbyte = pwdata[7:0];

   // every register answers at once; unmapped addresses flag an error
   always_comb begin
      unique case (paddr)
         ccpw_pkg::OFF_PT_COUNT, ccpw_pkg::OFF_PT_PERIOD, ccpw_pkg::OFF_PT_CONTROL,
         ccpw_pkg::OFF_AT_COUNT, ccpw_pkg::OFF_AT_PERIOD, ccpw_pkg::OFF_AT_CONTROL,
         ccpw_pkg::OFF_U4_DUTY_LOW, ccpw_pkg::OFF_U4_DUTY_HIGH, ccpw_pkg::OFF_U5_DUTY_LOW,
         ccpw_pkg::OFF_U5_DUTY_HIGH, ccpw_pkg::OFF_U4_CONTROL, ccpw_pkg::OFF_U5_CONTROL,
         ccpw_pkg::OFF_OPEN_DRAIN, ccpw_pkg::OFF_PIN_DIR, ccpw_pkg::OFF_TIMER_SEL,
         ccpw_pkg::OFF_STATUS: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pready = psel && penable;
   assign pslverr = psel && penable && !mapped;

   // read mux; narrow registers sit in the low bits, the rest read zero
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (paddr)
         ccpw_pkg::OFF_PT_COUNT: rd_val[7:0] = tbase[0].count;
         ccpw_pkg::OFF_PT_PERIOD: rd_val[7:0] = period_r[0];
         ccpw_pkg::OFF_PT_CONTROL: rd_val[6:0] = tctl_r[0];
         ccpw_pkg::OFF_AT_COUNT: rd_val[7:0] = tbase[1].count;
         ccpw_pkg::OFF_AT_PERIOD: rd_val[7:0] = period_r[1];
         ccpw_pkg::OFF_AT_CONTROL: rd_val[6:0] = tctl_r[1];
         ccpw_pkg::OFF_U4_DUTY_LOW: rd_val[7:0] = duty_low_r[0];
         ccpw_pkg::OFF_U4_DUTY_HIGH: rd_val[7:0] = buf_byte[0];
         ccpw_pkg::OFF_U5_DUTY_LOW: rd_val[7:0] = duty_low_r[1];
         ccpw_pkg::OFF_U5_DUTY_HIGH: rd_val[7:0] = buf_byte[1];
         ccpw_pkg::OFF_U4_CONTROL: rd_val[5:0] = uctl_r[0];
         ccpw_pkg::OFF_U5_CONTROL: rd_val[5:0] = uctl_r[1];
         ccpw_pkg::OFF_OPEN_DRAIN: rd_val[4:0] = open_drain_r;
         ccpw_pkg::OFF_PIN_DIR: rd_val[1:0] = pin_dir_r;
         ccpw_pkg::OFF_TIMER_SEL: rd_val[1:0] = timer_sel_r;
         ccpw_pkg::OFF_STATUS: begin
            rd_val[ccpw_pkg::ST_POST_LSB +: 2] = post_flag_r;
            rd_val[ccpw_pkg::ST_PIN_LSB +: 2] = level;
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // read data is caught in the setup cycle so it comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata <= rd_val;
      end
   end

   // timer control and period registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tctl_r[0] <= '0;
         tctl_r[1] <= '0;
         period_r[0] <= ccpw_pkg::RST_PERIOD;
         period_r[1] <= ccpw_pkg::RST_PERIOD;
      end else if (wr_acc) begin
         unique case (paddr)
            ccpw_pkg::OFF_PT_PERIOD: period_r[0] <= wbyte;
            ccpw_pkg::OFF_AT_PERIOD: period_r[1] <= wbyte;
            ccpw_pkg::OFF_PT_CONTROL: tctl_r[0] <= wbyte[6:0];
            ccpw_pkg::OFF_AT_CONTROL: tctl_r[1] <= wbyte[6:0];
            default: ;
         endcase
      end
   end

   // count writes go straight into the timer as a load strobe
   assign count_load[0] = wr_acc && (paddr == ccpw_pkg::OFF_PT_COUNT);
   assign count_load[1] = wr_acc && (paddr == ccpw_pkg::OFF_AT_COUNT);

   // duty and unit control registers; writable any time, duty bits used at rollover, mode at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         duty_low_r[0] <= 8'h00;
         duty_low_r[1] <= 8'h00;
         uctl_r[0] <= '0;
         uctl_r[1] <= '0;
      end else if (wr_acc) begin
         unique case (paddr)
            ccpw_pkg::OFF_U4_DUTY_LOW: duty_low_r[0] <= wbyte;
            ccpw_pkg::OFF_U5_DUTY_LOW: duty_low_r[1] <= wbyte;
            ccpw_pkg::OFF_U4_CONTROL: uctl_r[0] <= wbyte[5:0];
            ccpw_pkg::OFF_U5_CONTROL: uctl_r[1] <= wbyte[5:0];
            default: ;
         endcase
      end
   end

   // buffer byte writes are offered to the unit, which drops them in pwm mode
   assign buf_load[0] = wr_acc && (paddr == ccpw_pkg::OFF_U4_DUTY_HIGH);
   assign buf_load[1] = wr_acc && (paddr == ccpw_pkg::OFF_U5_DUTY_HIGH);

   // pin configuration: open drain, direction and timer choice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         open_drain_r <= 5'h00;
         pin_dir_r <= ccpw_pkg::RST_PIN_DIR;
         timer_sel_r <= 2'h0;
      end else if (wr_acc) begin
         unique case (paddr)
            ccpw_pkg::OFF_OPEN_DRAIN: open_drain_r <= wbyte[4:0];
            ccpw_pkg::OFF_PIN_DIR: pin_dir_r <= wbyte[1:0];
            ccpw_pkg::OFF_TIMER_SEL: timer_sel_r <= wbyte[1:0];
            default: ;
         endcase
      end
   end

   // postscale events are sticky; write one clears, a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         post_flag_r <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (post_evt[i]) begin
               post_flag_r[i] <= 1'b1;
            end else if (wr_acc && (paddr == ccpw_pkg::OFF_STATUS) && pwdata[ccpw_pkg::ST_POST_LSB + i]) begin
               post_flag_r[i] <= 1'b0;
            end
         end
      end
   end

   // two identical time bases
   genvar t;
   generate
      for (t = 0; t < 2; t++) begin : g_timer
         ccpw_timer u_timer (
            .pclk(pclk),
            .presetn(presetn),
            .ctl(tctl_r[t]),
            .period(period_r[t]),
            .load(count_load[t]),
            .load_val(wbyte),
            .tbase(tbase[t]),
            .post_evt(post_evt[t])
         );
      end
   endgenerate

   // pwm units with pin drivers; an open-drain pin only pulls low
   genvar u;
   generate
      for (u = 0; u < ccpw_pkg::NUM_UNITS; u++) begin : g_unit
         localparam int OD_BIT = (u == 0) ? ccpw_pkg::OD_U4_BIT : ccpw_pkg::OD_U5_BIT;
         assign pwm_en[u] = (uctl_r[u].mode[3:2] == ccpw_pkg::MODE_PWM_HI);
         ccpw_unit u_unit (
            .pclk(pclk),
            .presetn(presetn),
            .pwm_en(pwm_en[u]),
            .duty_byte(duty_low_r[u]),
            .duty_bits(uctl_r[u].duty_low_bits),
            .buf_load(buf_load[u]),
            .buf_val(wbyte),
            .tbase(tbase[timer_sel_r[u]]),
            .buf_byte(buf_byte[u]),
            .level(level[u])
         );
         // the unit latch drives the pin only when its direction is output
         always_comb begin
            if (open_drain_r[OD_BIT]) begin
               pwm_pin_out[u] = 1'b0;
               pwm_pin_oe[u] = !pin_dir_r[u] && !level[u];
            end else begin
               pwm_pin_out[u] = level[u];
               pwm_pin_oe[u] = !pin_dir_r[u];
            end
         end
      end
   endgenerate
endmodule : ccpw_top

/* sim/ccpw_props.sv */
// ccpw_props: port-level checks of the pwm block, its apb slave and its pins.
// assumes a zero-wait apb slave and the register map of ccpw_pkg.
`timescale 1ns/100ps
module ccpw_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [1:0] pwm_pin_out,
   input wire logic [1:0] pwm_pin_oe
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // apb handshake: zero wait states, errors only on unmapped words
   a_ready_in_access: assert property (psel && penable |-> pready) else $error("pready missing");
   a_ready_when_idle: assert property (!(psel && penable) |-> !pready) else $error("stray pready");
   a_err_in_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
   a_err_unmapped: assert property (psel && penable && paddr > 8'h3c |-> pslverr) else $error("no pslverr");
   a_ok_mapped: assert property (psel && penable && paddr <= 8'h3c && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("pslverr on mapped word");
   a_rdata_unmapped: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("unmapped read data");
   // read data only moves after a setup cycle, so it cannot glitch mid-access
   a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
   // pins stay quiet after reset until software can enable a unit
   a_reset_quiet: assert property ($rose(presetn) |-> (pwm_pin_out == 2'h0 && pwm_pin_oe == 2'h0)[*3])
      else $error("pins active after reset");
   // shortest period is one timer tick of four oscillator cycles
   a_rise_spacing: assert property ($rose(pwm_pin_out[0]) |=> (!$rose(pwm_pin_out[0]))[*3])
      else $error("unit4 period too short");
   a_fall_spacing: assert property ($fell(pwm_pin_out[1]) |=> (!$fell(pwm_pin_out[1]))[*3])
      else $error("unit5 falls too close");

   c_rise_u4: cover property ($rose(pwm_pin_out[0]));
   c_rise_u5: cover property ($rose(pwm_pin_out[1]));
   c_err: cover property (pslverr);
endmodule : ccpw_props

bind ccpw_top ccpw_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .pwm_pin_out(pwm_pin_out), .pwm_pin_oe(pwm_pin_oe));

/* sim/ccpw_test.sv */
// ccpw_test: self-checking bench for the pwm block over its apb port and pins.
// assumes unit4 runs on the primary timer and unit5 on the alternate one.
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
   $display("[FAIL] t=%0t got %0h exp %0h", $time, (a), (e)); end end
module ccpw_test;
   typedef struct {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] x; logic e;} ccpw_reg_row_t;
   typedef struct {int u; logic [7:0] tc; logic [7:0] p; logic [7:0] db; logic [1:0] dl;} ccpw_pwm_row_t;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [1:0] pwm_pin_out;
   logic [1:0] pwm_pin_oe;
   int n_errors = 0;
   int checks_done = 0;
   int hi;
   int per;
   int lows;
   logic [31:0] rd;
   logic er;
   // reset values, access kinds, read-only buffer in pwm mode, unmapped word
   ccpw_reg_row_t regs [14] = '{'{8'h04, 0, 8'h00, 8'hff, 0}, '{8'h10, 0, 8'h00, 8'hff, 0},
      '{8'h34, 0, 8'h00, 8'h03, 0}, '{8'h28, 0, 8'h00, 8'h00, 0}, '{8'h08, 1, 8'hfb, 8'h00, 0},
      '{8'h08, 0, 8'h00, 8'h7b, 0}, '{8'h08, 1, 8'h00, 8'h00, 0}, '{8'h2c, 1, 8'hff, 8'h00, 0},
      '{8'h2c, 0, 8'h00, 8'h3f, 0}, '{8'h24, 1, 8'h55, 8'h00, 0}, '{8'h24, 0, 8'h00, 8'h00, 0},
      '{8'h2c, 1, 8'h00, 8'h00, 0}, '{8'h40, 1, 8'hff, 8'h00, 1}, '{8'h40, 0, 8'h00, 8'h00, 1}};
   // every prescale code, postscale on and off, the shortest period
   ccpw_pwm_row_t pw [5] = '{'{0, 8'h04, 8'h04, 8'h02, 2'h1}, '{1, 8'h05, 8'h03, 8'h01, 2'h3},
      '{0, 8'h07, 8'h02, 8'h00, 2'h2}, '{1, 8'h7e, 8'h01, 8'h01, 2'h0}, '{0, 8'h3c, 8'h00, 8'h00, 2'h3}};

   ccpw_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .pwm_pin_out, .pwm_pin_oe);

   // 125 MHz oscillator clock
   always #4 pclk = ~pclk;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   // one apb transfer; starts at the next edge so back-to-back calls never collide
   task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do begin @(posedge pclk); k++; end while (pready !== 1'h1 && k < 20);
      if (pready !== 1'h1) begin
         n_errors++;
         wrap_up();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(a, 1'h1, d, r, e);
   endtask : wr

   // looks for a rising pin within lim cycles; a missing wanted rise ends the run
   task automatic wait_rise(input int u, input int lim, input logic want);
      logic prev;
      logic ok;
      ok = 1'h0;
      prev = pwm_pin_out[u];
      for (int k = 0; k < lim && !ok; k++) begin
         @(posedge pclk);
         #1;
         ok = (pwm_pin_out[u] === 1'h1 && prev === 1'h0);
         prev = pwm_pin_out[u];
      end
      `CHK(ok, want)
      if (want && !ok) wrap_up();
   endtask : wait_rise

   // from a rise to the next rise: high cycles and whole period
   task automatic span(input int u, output int h, output int p);
      logic prev;
      h = 1;
      p = 1;
      prev = 1'h1;
      for (int k = 0; k < 2000; k++) begin
         @(posedge pclk);
         #1;
         if (pwm_pin_out[u] === 1'h1 && prev === 1'h0) return;
         p++;
         if (pwm_pin_out[u] === 1'h1) h++;
         prev = pwm_pin_out[u];
      end
      n_errors++;
      wrap_up();
   endtask : span

   // setup order: stop, count, period, duty, timer, then pwm mode
   task automatic cfg(input int u, input logic [7:0] tc, input logic [7:0] p, input logic [7:0] db,
                      input logic [1:0] dl);
      logic [7:0] uo;
      uo = 8'(u);
      wr(8'h28 + (uo << 2), 8'h00);
      wr(8'h08 + uo * 8'h0c, 8'h00);
      wr(8'h00 + uo * 8'h0c, 8'h00);
      wr(8'h04 + uo * 8'h0c, p);
      wr(8'h18 + (uo << 3), db);
      wr(8'h28 + (uo << 2), {2'h0, dl, 4'h0});
      wr(8'h08 + uo * 8'h0c, tc);
      wr(8'h28 + (uo << 2), {2'h0, dl, 4'hc});
   endtask : cfg

   // watchdog against a hung handshake or wait
   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      wrap_up();
   end

   // main sequence
   initial begin
      int ps;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      foreach (regs[i]) begin
         apb(regs[i].a, regs[i].w, regs[i].d, rd, er);
         `CHK(er, regs[i].e)
         if (!regs[i].w) `CHK(rd, {24'h0, regs[i].x})
      end
      $display("register table done");
      wr(8'h38, 8'h02);
      wr(8'h34, 8'h00);
      #1;
      `CHK(pwm_pin_oe, 2'h3)
      foreach (pw[i]) begin
         cfg(pw[i].u, pw[i].tc, pw[i].p, pw[i].db, pw[i].dl);
         wait_rise(pw[i].u, 2000, 1'h1);
         span(pw[i].u, hi, per);
         ps = (pw[i].tc[1:0] == 2'h0) ? 1 : (pw[i].tc[1:0] == 2'h1) ? 4 : 16;
         `CHK(hi, {pw[i].db, pw[i].dl} * ps)
         `CHK(per, (pw[i].p + 1) * 4 * ps)
         apb(8'h1c + 8'(pw[i].u * 8), 1'h0, 8'h00, rd, er);
         `CHK(rd, {24'h0, pw[i].db})
      end
      $display("waveform table done");
      cfg(0, 8'h04, 8'h09, 8'h04, 2'h0);
      wait_rise(0, 200, 1'h1);
      fork
         span(0, hi, per);
         wr(8'h18, 8'h06);
      join
      `CHK(hi, 16)
      span(0, hi, per);
      `CHK(hi, 24)
      $display("mid-period duty change done");
      wr(8'h18, 8'h00);
      // let the period already under way finish before watching for rises
      repeat (48) @(posedge pclk);
      wait_rise(0, 200, 1'h0);
      `CHK(pwm_pin_out[0], 1'h0)
      $display("zero duty done");
      wr(8'h18, 8'h20);
      wait_rise(0, 200, 1'h1);
      lows = 0;
      repeat (120) begin
         @(posedge pclk);
         #1;
         if (pwm_pin_out[0] !== 1'h1) lows++;
      end
      `CHK(lows, 0)
      // status: both postscale flags set earlier, unit4 level held high
      apb(8'h3c, 1'h0, 8'h00, rd, er);
      `CHK(rd[2:0], 3'h7)
      // open drain releases the pin while the level is high
      wr(8'h30, 8'h08);
      #1;
      `CHK({pwm_pin_out[0], pwm_pin_oe[0]}, 2'h0)
      wr(8'h30, 8'h00);
      wr(8'h28, 8'h00);
      @(posedge pclk);
      #1;
      `CHK(pwm_pin_out[0], 1'h0)
      $display("long duty and unit clear done");
      @(posedge pclk);
      presetn <= 1'h0;
      #1;
      `CHK(pwm_pin_out, 2'h0)
      `CHK(pwm_pin_oe, 2'h0)
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      apb(8'h04, 1'h0, 8'h00, rd, er);
      `CHK(rd, 32'h000000ff)
      $display("mid-run reset done");
      wrap_up();
   end
endmodule : ccpw_test
